// ===== pkg/afepgs_regs.svh
/*
 * Offsets, field positions, reset values and timing counts of the phase,
 * gain and status/communication register bank.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef AFEPGS_REGS_SVH
`define AFEPGS_REGS_SVH

// ====================================================================
// register offsets (5-bit serial register address)
`define AFEPGS_ADDR_PHASE 5'h0a
`define AFEPGS_ADDR_GAIN 5'h0b
`define AFEPGS_ADDR_STATUS 5'h0c
`define AFEPGS_ADDR_CHAN_LAST 5'h07
`define AFEPGS_ADDR_TYPE2_FIRST 5'h08
`define AFEPGS_ADDR_WR_FIRST 5'h09
`define AFEPGS_ADDR_MAP_LAST 5'h1f
`define AFEPGS_GROUP_MASK 5'h18

// ====================================================================
// field positions
`define AFEPGS_PHASE_HI_LSB 12
`define AFEPGS_CTRL_LSB 12
`define AFEPGS_GAIN_BITS 3

// ====================================================================
// reset values and masks
`define AFEPGS_PHASE_RESET 24'h000000
`define AFEPGS_GAIN_RESET 24'h000000
`define AFEPGS_CTRL_RESET 12'ha90
`define AFEPGS_FLAGS_RESET 8'hff
`define AFEPGS_UNLOCK_KEY 8'ha5
`define AFEPGS_CRC_POLY 16'h8005
`define AFEPGS_CRC_SEED 16'h0000
`define AFEPGS_GAIN_MAX_CODE 3'h5

// ====================================================================
// timing
`define AFEPGS_CLK_MHZ 20
`define AFEPGS_READY_LOW_NS 100
`define AFEPGS_READY_LOW_CYC \
    ((`AFEPGS_READY_LOW_NS * `AFEPGS_CLK_MHZ + 999) / 1000)

`endif

// ===== pkg/afepgs_pkg.sv
/*
 * Types and the checksum step shared by the register bank modules.
 * Assumes afepgs_regs.svh is on the include path.
 */
package afepgs_pkg;
`include "afepgs_regs.svh"

    // ================================================================
    // configuration half of the status/communication register
    typedef struct packed {
        logic [1:0] readIncr;
        logic writeIncr;
        logic readyPinIdleDrive;
        logic readyPulseMerge;
        logic checksumWide;
        logic [1:0] dataWidth;
        logic transactionChecksumEnable;
        logic mapIntEnable;
        logic [1:0] reservedBits;
    } afepgs_ctrl_t;

    typedef struct packed {
        logic [11:0] pair23Delay;
        logic [11:0] pair01Delay;
    } afepgs_phase_t;

    typedef enum logic [1:0] {
        SPI_IDLE,
        SPI_CMD,
        SPI_DATA,
        SPI_TAIL
    } afepgs_spi_state_t;

    // ================================================================
    // one bit of the checksum shift
    function automatic logic [15:0] afepgs_crc_step(input logic [15:0] crc,
                                                   input logic bitIn);
        afepgs_crc_step = {crc[14:0], 1'b0} ^
            ((crc[15] ^ bitIn) ? `AFEPGS_CRC_POLY : 16'h0000);
    endfunction
endpackage

// ===== core/afepgs_ready_pin.sv
/*
 * Drives the active-low data-ready pin: a low pulse per ready event,
 * held low while the map checksum alarm stands, idle high or released.
 * Assumes events are one-cycle pulses on clk.
 */
`include "afepgs_regs.svh"

module afepgs_ready_pin #(
    parameter int LOW_CYCLES = `AFEPGS_READY_LOW_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // control
    input wire logic readyEvent,
    input wire logic idleDrive,
    input wire logic alarmHold,
    // pin
    output logic readyPinN,
    output logic readyPinOe
);
    import afepgs_pkg::*;

    logic [7:0] lowCount;
    logic pulsing;

    // ================================================================
    // pulse timer
    assign pulsing = (lowCount != 8'h00);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lowCount <= 8'h00;
        end else if (readyEvent) begin
            lowCount <= 8'(LOW_CYCLES);
        end else if (pulsing) begin
            lowCount <= lowCount - 8'h01;
        end
    end

    // ================================================================
    // pin drive
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            readyPinN <= 1'b1;
            readyPinOe <= 1'b0;
        end else if (alarmHold || readyEvent || pulsing) begin
            readyPinN <= 1'b0;
            readyPinOe <= 1'b1;
        end else begin
            readyPinN <= 1'b1;
            readyPinOe <= idleDrive;
        end
    end
endmodule

// ===== core/afepgs_top.sv
/*
 * Phase, gain and status/communication register bank of an eight-channel
 * converter front end, reached over the serial port (mode 0,0 or 1,1).
 * Assumes: serial pins are asynchronous and slow against clk (at least
 * four clk periods per serial half period); converter pulses, data,
 * active mask, map checksum error and lock writes are on clk.
 */
`include "afepgs_regs.svh"

module afepgs_top (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // serial port
    input wire logic spiCsN,
    input wire logic spiSck,
    input wire logic spiSdi,
    output logic spiSdo,
    output logic spiSdoOe,
    // data-ready pin
    output logic readyPinN,
    output logic readyPinOe,
    // converter side
    input wire logic [7:0][23:0] chanData,
    input wire logic [7:0] chanPulse,
    input wire logic [7:0] activeMask,
    output logic [7:0] chanRestart,
    output afepgs_pkg::afepgs_phase_t phaseDelay,
    output logic [7:0][2:0] gainShift,
    output afepgs_pkg::afepgs_ctrl_t commCtrl,
    // map checksum and lock
    input wire logic mapChecksumError,
    input wire logic lockWrite,
    input wire logic [7:0] lockValue,
    output logic [15:0] mapChecksumValue,
    output logic mapAlarm
);
    import afepgs_pkg::*;

    // ================================================================
    // declarations
    logic [1:0] csSync, sckSync, sdiSync;
    logic sckPrev, sckRise, sckFall, csActive, sdiBit;
    afepgs_spi_state_t spiState;
    logic [5:0] bitCnt, wordLen;
    logic [31:0] rxShift, txShift;
    logic [4:0] curAddr;
    logic isRead, loadWord, loadCrc;
    logic [15:0] txnCrc;
    logic wrPulse, rdStatus;
    logic [4:0] wrAddr;
    logic [23:0] wrData;
    logic [23:0] gainReg;
    logic [7:0] readyFlags;
    logic [7:0][23:0] chanLatch;
    logic [7:0] mergePending;
    logic [7:0] next_pending;
    logic mergedFire, readyEvent;
    logic [7:0] eventMask;
    logic [31:0] wordValue;
    logic [5:0] addrLen;
    logic [15:0] next_mapCrc;

    // ================================================================
    // serial pin synchronisers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            csSync <= 2'h3;
            sckSync <= 2'h0;
            sdiSync <= 2'h0;
        end else begin
            csSync <= {csSync[0], spiCsN};
            sckSync <= {sckSync[0], spiSck};
            sdiSync <= {sdiSync[0], spiSdi};
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sckPrev <= 1'b0;
        end else begin
            sckPrev <= sckSync[1];
        end
    end

    assign csActive = !csSync[1];
    assign sdiBit = sdiSync[1];
    assign sckRise = csActive && sckSync[1] && !sckPrev;
    assign sckFall = csActive && !sckSync[1] && sckPrev;

    // ================================================================
    // address walk
    function automatic logic [4:0] next_addr(input logic [4:0] a,
                                             input logic rd);
        logic [4:0] lo, hi;
        lo = 5'h00;
        hi = `AFEPGS_ADDR_MAP_LAST;
        if (!rd) begin
            lo = `AFEPGS_ADDR_WR_FIRST;
            if (!commCtrl.writeIncr) begin
                hi = a;
                lo = a;
            end
        end else begin
            case (commCtrl.readIncr)
                2'b11: begin
                    lo = 5'h00;
                end
                2'b10: begin
                    if (a <= `AFEPGS_ADDR_CHAN_LAST) begin
                        hi = `AFEPGS_ADDR_CHAN_LAST;
                    end else begin
                        lo = `AFEPGS_ADDR_TYPE2_FIRST;
                    end
                end
                2'b01: begin
                    lo = a & `AFEPGS_GROUP_MASK;
                    hi = lo | ~`AFEPGS_GROUP_MASK;
                end
                default: begin
                    lo = a;
                    hi = a;
                end
            endcase
        end
        next_addr = (a >= hi || a < lo) ? lo : a + 5'h01;
    endfunction

    // ================================================================
    // read word, left aligned, and its length
    always_comb begin
        logic [23:0] d;
        logic [16:0] rounded;
        d = chanLatch[curAddr[2:0]];
        rounded = {1'b0, d[23:8]} + {16'h0000, d[7]};
        wordValue = 32'h00000000;
        addrLen = 6'd24;
        if (curAddr <= `AFEPGS_ADDR_CHAN_LAST) begin
            case (commCtrl.dataWidth)
                2'b11: begin
                    wordValue = {{8{d[23]}}, d};
                    addrLen = 6'd32;
                end
                2'b10: begin
                    wordValue = {d, 8'h00};
                    addrLen = 6'd32;
                end
                2'b01: begin
                    wordValue = {d, 8'h00};
                end
                default: begin
                    // saturate where rounding would flip the sign
                    wordValue[31:16] = (!d[23] && rounded[15]) ?
                        16'h7fff : rounded[15:0];
                    addrLen = 6'd16;
                end
            endcase
        end else if (curAddr == `AFEPGS_ADDR_PHASE) begin
            wordValue = {phaseDelay, 8'h00};
        end else if (curAddr == `AFEPGS_ADDR_GAIN) begin
            wordValue = {gainReg, 8'h00};
        end else if (curAddr == `AFEPGS_ADDR_STATUS) begin
            wordValue = {commCtrl, 4'h0, readyFlags, 8'h00};
        end
    end

    // ================================================================
    // serial engine
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            spiState <= SPI_IDLE;
            bitCnt <= 6'd0;
            wordLen <= 6'd24;
            rxShift <= 32'h00000000;
            txShift <= 32'h00000000;
            curAddr <= 5'h00;
            isRead <= 1'b0;
            loadWord <= 1'b0;
            loadCrc <= 1'b0;
            txnCrc <= `AFEPGS_CRC_SEED;
            wrPulse <= 1'b0;
            wrAddr <= 5'h00;
            wrData <= 24'h000000;
            rdStatus <= 1'b0;
        end else begin
            wrPulse <= 1'b0;
            rdStatus <= 1'b0;
            if (!csActive) begin
                spiState <= SPI_IDLE;
                loadWord <= 1'b0;
                loadCrc <= 1'b0;
                txShift <= 32'h00000000;
            end else if (spiState == SPI_IDLE) begin
                spiState <= SPI_CMD;
                bitCnt <= 6'd0;
                txnCrc <= `AFEPGS_CRC_SEED;
            end else if (sckRise) begin
                rxShift <= {rxShift[30:0], sdiBit};
                bitCnt <= bitCnt + 6'd1;
                if (spiState != SPI_TAIL) begin
                    txnCrc <= afepgs_crc_step(txnCrc,
                        (isRead && spiState == SPI_DATA) ?
                        txShift[31] : sdiBit);
                end
                if (spiState == SPI_CMD && bitCnt == 6'd7) begin
                    // command: two device bits, five address, read flag
                    curAddr <= rxShift[4:0];
                    isRead <= sdiBit;
                    loadWord <= sdiBit;
                    spiState <= SPI_DATA;
                    bitCnt <= 6'd0;
                end else if (spiState == SPI_DATA &&
                             bitCnt == wordLen - 6'd1) begin
                    bitCnt <= 6'd0;
                    if (!isRead) begin
                        wrPulse <= 1'b1;
                        wrAddr <= curAddr;
                        wrData <= {rxShift[22:0], sdiBit};
                    end
                    if (commCtrl.transactionChecksumEnable) begin
                        spiState <= SPI_TAIL;
                        loadCrc <= 1'b1;
                    end else begin
                        curAddr <= next_addr(curAddr, isRead);
                        loadWord <= isRead;
                    end
                end
            end else if (sckFall) begin
                if (loadWord) begin
                    txShift <= wordValue;
                    wordLen <= addrLen;
                    loadWord <= 1'b0;
                    rdStatus <= (curAddr == `AFEPGS_ADDR_STATUS);
                end else if (loadCrc) begin
                    // checksum then 16 zeros, narrow or wide alike; checksumWide is not used
                    txShift <= {txnCrc, 16'h0000};
                    loadCrc <= 1'b0;
                end else begin
                    txShift <= {txShift[30:0], 1'b0};
                end
            end
            // reads set their own length at the word load
            if (spiState == SPI_CMD) begin
                wordLen <= 6'd24;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            spiSdo <= 1'b0;
            spiSdoOe <= 1'b0;
        end else begin
            spiSdo <= txShift[31];
            spiSdoOe <= csActive;
        end
    end

    // ================================================================
    // writable registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phaseDelay <= `AFEPGS_PHASE_RESET;
            gainReg <= `AFEPGS_GAIN_RESET;
            commCtrl <= `AFEPGS_CTRL_RESET;
        end else if (wrPulse) begin
            case (wrAddr)
                `AFEPGS_ADDR_PHASE: begin
                    phaseDelay <= wrData;
                end
                `AFEPGS_ADDR_GAIN: begin
                    gainReg <= wrData;
                end
                `AFEPGS_ADDR_STATUS: begin
                    // reserved pair stored as written; host keeps it zero
                    commCtrl <= wrData[23:`AFEPGS_CTRL_LSB];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            chanRestart <= 8'h00;
        end else begin
            chanRestart <= (wrPulse && wrAddr == `AFEPGS_ADDR_PHASE) ?
                activeMask : 8'h00;
        end
    end

    // ================================================================
    // gain decode: shift amount is log2 of the gain
    for (genvar ch = 0; ch < 8; ch++) begin : g_gain
        logic [2:0] code;
        assign code = gainReg[ch*`AFEPGS_GAIN_BITS +: `AFEPGS_GAIN_BITS];
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                gainShift[ch] <= 3'h0;
            end else if (code > `AFEPGS_GAIN_MAX_CODE) begin
                gainShift[ch] <= 3'h0;
            end else begin
                gainShift[ch] <= code;
            end
        end
    end

    // ================================================================
    // ready events and channel data latching
    always_comb begin
        next_pending = mergePending | chanPulse;
        mergedFire = (|chanPulse) && (activeMask != 8'h00) &&
            ((next_pending & activeMask) == activeMask);
        if (commCtrl.readyPulseMerge) begin
            eventMask = mergedFire ? activeMask : 8'h00;
            readyEvent = mergedFire;
        end else begin
            eventMask = chanPulse;
            readyEvent = |chanPulse;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mergePending <= 8'h00;
        end else if (!commCtrl.readyPulseMerge || mergedFire) begin
            mergePending <= 8'h00;
        end else begin
            mergePending <= next_pending;
        end
    end

    for (genvar ch = 0; ch < 8; ch++) begin : g_latch
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                chanLatch[ch] <= 24'h000000;
            end else if (commCtrl.readyPulseMerge ? mergedFire
                         : chanPulse[ch]) begin
                chanLatch[ch] <= chanData[ch];
            end
        end
    end

    // a fresh event wins over the clear of a status read
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            readyFlags <= `AFEPGS_FLAGS_RESET;
        end else begin
            readyFlags <= (readyFlags | {8{rdStatus}}) & ~eventMask;
        end
    end

    // ================================================================
    // map checksum and alarm
    always_comb begin
        logic [71:0] image;
        image = {phaseDelay, gainReg, commCtrl, 12'h000};
        next_mapCrc = `AFEPGS_CRC_SEED;
        for (int i = 71; i >= 0; i--) begin
            next_mapCrc = afepgs_crc_step(next_mapCrc, image[i]);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mapChecksumValue <= `AFEPGS_CRC_SEED;
        end else begin
            mapChecksumValue <= next_mapCrc;
        end
    end

    // error sets win over the key release in the same cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mapAlarm <= 1'b0;
        end else if (mapChecksumError && commCtrl.mapIntEnable) begin
            mapAlarm <= 1'b1;
        end else if (lockWrite && lockValue == `AFEPGS_UNLOCK_KEY) begin
            mapAlarm <= 1'b0;
        end
    end

    // ================================================================
    // data-ready pin
    afepgs_ready_pin u_ready_pin (
        .clk(clk),
        .arst_n(arst_n),
        .readyEvent(readyEvent),
        .idleDrive(commCtrl.readyPinIdleDrive),
        .alarmHold(mapAlarm),
        .readyPinN(readyPinN),
        .readyPinOe(readyPinOe)
    );
endmodule

// ===== tb/afepgs_top_assertions.sv
/*
 * Port checker for the phase, gain and status register bank.
 * Assumes bound into afepgs_top; a single clock domain.
 */
module afepgs_top_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // converter side
    input wire logic [7:0] chanPulse,
    input wire logic [7:0] activeMask,
    input wire logic [7:0] chanRestart,
    input wire afepgs_pkg::afepgs_ctrl_t commCtrl,
    // pin
    input wire logic readyPinN,
    input wire logic readyPinOe,
    // alarm and lock
    input wire logic mapChecksumError,
    input wire logic lockWrite,
    input wire logic [7:0] lockValue,
    input wire logic mapAlarm
);
    timeunit 1ns;
    timeprecision 1ps;
    import afepgs_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic unlock;
    logic armed;
    assign unlock = lockWrite && lockValue == 8'ha5;
    assign armed = mapChecksumError && commCtrl.mapIntEnable;
    // ================================================================
    sequence s_low2;
        (!readyPinN && readyPinOe) [*2];
    endsequence
    sequence s_restart;
        (chanRestart == $past(activeMask)) ##1 (chanRestart == 8'h00);
    endsequence
    a_restart_mask: assert property (|chanRestart |-> s_restart)
        else $error("restart pulse differs from active mask");
    // pin registered from the control bits, so wait for them to settle
    a_idle_level: assert property (readyPinN && $stable(commCtrl)
        |-> readyPinOe == commCtrl.readyPinIdleDrive)
        else $error("idle pin drive wrong");
    a_low_pulse: assert property (!commCtrl.readyPulseMerge
        && |chanPulse |=> s_low2)
        else $error("ready pulse missing or short");
    a_alarm_set: assert property (armed |=> mapAlarm)
        else $error("alarm not raised");
    a_alarm_pin: assert property (mapAlarm && $past(mapAlarm)
        |-> !readyPinN && readyPinOe)
        else $error("alarm does not hold pin low");
    a_alarm_keep: assert property (mapAlarm && !unlock |=> mapAlarm)
        else $error("alarm dropped without key");
    a_alarm_clear: assert property (unlock && !armed |=> !mapAlarm)
        else $error("alarm not cleared by key");
    a_alarm_quiet: assert property (!mapAlarm && !armed |=> !mapAlarm)
        else $error("alarm raised while disabled");
endmodule

bind afepgs_top afepgs_top_assertions u_chk (
    .clk(clk), .arst_n(arst_n), .chanPulse(chanPulse),
    .activeMask(activeMask), .chanRestart(chanRestart),
    .commCtrl(commCtrl), .readyPinN(readyPinN), .readyPinOe(readyPinOe),
    .mapChecksumError(mapChecksumError), .lockWrite(lockWrite),
    .lockValue(lockValue), .mapAlarm(mapAlarm)
);

// ===== tb/afepgs_host.sv
/*
 * Host controller model: serial master, mode 0,0, 400 ns bit period.
 * Assumes a 50 ns clk; all pins change on its falling edge.
 */
module afepgs_host (
    // clock
    input wire logic clk,
    // serial port
    output logic spiCsN,
    output logic spiSck,
    output logic spiSdi,
    input wire logic spiSdo,
    // captured read word
    output logic [23:0] rxWord,
    output logic rxDone
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        spiCsN = 1'b1;
        spiSck = 1'b0;
        spiSdi = 1'b0;
        rxWord = 24'h000000;
        rxDone = 1'b0;
    end
    // ================================================================
    // one command plus one or two 24-bit words, then select released
    task automatic xfer(input logic [4:0] a, input logic rd,
                        input logic [23:0] wd, input logic two = 1'b0);
        logic [55:0] sh;
        sh = {2'b01, a, rd, wd, wd};
        @(negedge clk);
        spiCsN = 1'b0;
        repeat (4) @(negedge clk);
        for (int i = 55; i >= (two ? 0 : 24); i--) begin
            spiSdi = sh[i];
            repeat (4) @(negedge clk);
            spiSck = 1'b1;
            if (i < 48) rxWord = {rxWord[22:0], spiSdo};
            repeat (4) @(negedge clk);
            spiSck = 1'b0;
        end
        repeat (4) @(negedge clk);
        spiCsN = 1'b1;
        // no stale level left on the data line after release
        spiSdi = ~spiSdi;
        rxDone = rd;
        @(negedge clk);
        rxDone = 1'b0;
        repeat (8) @(negedge clk);
    endtask
endmodule

// ===== tb/afe_phase_gain_status_regs_tb.sv
/*
 * Self-checking bench of the phase, gain and status register bank.
 * Assumes afepgs_pkg compiled first and the host model beside it.
 */
`define CHK(nm, e, s) begin num_checks++; if ((e) !== (s)) begin \
    mismatches++; $display("[FAIL] %s exp %h got %h", nm, e, s); end end
module afe_phase_gain_status_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import afepgs_pkg::*;
    logic clk, arst_n, spiCsN, spiSck, spiSdi, spiSdo, spiSdoOe;
    logic readyPinN, readyPinOe, mapChecksumError, lockWrite, mapAlarm;
    logic rxDone;
    logic [7:0][23:0] chanData;
    logic [7:0][2:0] gainShift;
    logic [7:0] chanPulse, activeMask, chanRestart, lockValue;
    logic [15:0] mapChecksumValue;
    logic [23:0] rxWord, expv, rnd;
    logic [23:0] expQ[$];
    logic [71:0] mapImg;
    logic [15:0] expCrc;
    afepgs_phase_t phaseDelay;
    afepgs_ctrl_t commCtrl;
    int mismatches, num_checks, cycles, restarts;
    afepgs_top u_afepgs_top (.clk(clk), .arst_n(arst_n),
        .spiCsN(spiCsN), .spiSck(spiSck), .spiSdi(spiSdi), .spiSdo(spiSdo),
        .spiSdoOe(spiSdoOe), .readyPinN(readyPinN), .readyPinOe(readyPinOe),
        .chanData(chanData), .chanPulse(chanPulse), .activeMask(activeMask),
        .chanRestart(chanRestart), .phaseDelay(phaseDelay),
        .gainShift(gainShift), .commCtrl(commCtrl),
        .mapChecksumError(mapChecksumError), .lockWrite(lockWrite),
        .lockValue(lockValue), .mapChecksumValue(mapChecksumValue),
        .mapAlarm(mapAlarm));
    afepgs_host u_afepgs_host (.clk(clk), .spiCsN(spiCsN),
        .spiSck(spiSck), .spiSdi(spiSdi), .spiSdo(spiSdo),
        .rxWord(rxWord), .rxDone(rxDone));
    // ================================================================
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (|chanRestart) restarts++;
        if (rxDone) begin
            expv = expQ.pop_front();
            `CHK("spi read", expv, rxWord)
        end
        if (cycles == 20000) begin
            mismatches++;
            end_sim();
        end
    end
    task automatic end_sim();
        if (mismatches == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic rd(input logic [4:0] a, input logic [23:0] e,
                      input logic two = 1'b0);
        expQ.push_back(e);
        u_afepgs_host.xfer(a, 1'b1, 24'h000000, two);
    endtask
    task automatic strobe(input logic [7:0] pm, input logic err,
                          input logic lk, input logic [7:0] lv);
        @(negedge clk);
        chanPulse = pm;
        mapChecksumError = err;
        lockWrite = lk;
        lockValue = lv;
        @(negedge clk);
        chanPulse = 8'h00;
        mapChecksumError = 1'b0;
        lockWrite = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    initial begin
        {arst_n, mapChecksumError, lockWrite} = 3'b000;
        {chanPulse, activeMask, lockValue} = 24'h000000;
        chanData = '0;
        {mismatches, num_checks, cycles, restarts} = '0;
        rnd = $urandom(12);
        repeat (4) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        `CHK("idle oe", 2'b00, {readyPinOe, spiSdoOe})
        rd(5'h0c, 24'ha900ff);
        // type loop walks from the gain register on to the status word
        rd(5'h0b, 24'ha900ff, 1'b1);
        rnd = $urandom;
        activeMask = rnd[7:0] | 8'h01;
        for (int i = 0; i < 8; i++) chanData[i] = $urandom;
        rnd = $urandom;
        // second word lands on the next writable register
        u_afepgs_host.xfer(5'h0a, 1'b0, rnd, 1'b1);
        `CHK("restart", 1, restarts)
        `CHK("phase", rnd, phaseDelay)
        rd(5'h0a, rnd);
        rd(5'h0b, rnd);
        // gain codes 0..7 on channels 0..7
        u_afepgs_host.xfer(5'h0b, 1'b0, 24'hfac688);
        for (int i = 0; i < 8; i++)
            `CHK("gain", (i < 6) ? 3'(i) : 3'h0, gainShift[i])
        // same-address reads, idle drive high, alarm enabled
        u_afepgs_host.xfer(5'h0c, 1'b0, 24'h314000);
        `CHK("ctrl", 12'h314, commCtrl)
        strobe(8'h08, 1'b0, 1'b0, 8'h00);
        `CHK("pin idle", 2'b11, {readyPinN, readyPinOe})
        rd(5'h0c, 24'h3140f7);
        rd(5'h0c, 24'h3140ff);
        strobe(8'h20, 1'b0, 1'b0, 8'h00);
        rd(5'h05, chanData[5]);
        rd(5'h0c, 24'h3140df);
        strobe(8'h00, 1'b1, 1'b0, 8'h00);
        `CHK("alarm pin", 2'b10, {mapAlarm, readyPinN})
        strobe(8'h00, 1'b0, 1'b1, 8'h5a);
        `CHK("wrong key", 1'b1, mapAlarm)
        strobe(8'h00, 1'b0, 1'b1, 8'ha5);
        `CHK("key", 3'b011, {mapAlarm, readyPinN, readyPinOe})
        u_afepgs_host.xfer(5'h0c, 1'b0, 24'h310000);
        strobe(8'h00, 1'b1, 1'b0, 8'h00);
        `CHK("alarm off", 1'b0, mapAlarm)
        // merged event: channel 0 alone must neither flag nor latch
        u_afepgs_host.xfer(5'h0c, 1'b0, 24'h390000);
        activeMask = 8'h03;
        strobe(8'h01, 1'b0, 1'b0, 8'h00);
        chanData[0] = ~chanData[0];
        rd(5'h0c, 24'h3900ff);
        strobe(8'h02, 1'b0, 1'b0, 8'h00);
        rd(5'h0c, 24'h3900fc);
        rd(5'h00, chanData[0]);
        // crc-16, poly 8005, seed 0, over phase, gain, control, zeros
        mapImg = {rnd, 24'hfac688, 12'h390, 12'h000};
        expCrc = 16'h0000;
        for (int i = 71; i >= 0; i--)
            expCrc = {expCrc[14:0], 1'b0} ^
                ((expCrc[15] ^ mapImg[i]) ? 16'h8005 : 16'h0000);
        `CHK("map crc", expCrc, mapChecksumValue)
        end_sim();
    end
endmodule
